// ### hdl/cam_pkg.sv
// Package with constants and carrier types for the counter array mode control.
package cam_pkg;

  // ----------------------------------------------------------------------------
  // Mode register layout and reset value
  // ----------------------------------------------------------------------------
  localparam int unsigned IDLE_SUSPEND_BIT  = 7;
  localparam int unsigned WD_ENABLE_BIT     = 6;
  localparam int unsigned WD_LOCK_BIT       = 5;
  localparam int unsigned TIMEBASE_LSB      = 1;
  localparam int unsigned OVF_IRQ_EN_BIT    = 0;
  localparam logic [7:0]  MODE_RESET        = 8'h40;
  localparam logic [7:0]  MODE_WRITE_MASK   = 8'hEF;

  // ----------------------------------------------------------------------------
  // Timebase select codes
  // ----------------------------------------------------------------------------
  localparam logic [2:0]  TB_SYS_DIV12      = 3'h0;
  localparam logic [2:0]  TB_SYS_DIV4       = 3'h1;
  localparam logic [2:0]  TB_TIMER0_OVF     = 3'h2;
  localparam logic [2:0]  TB_EXT_FALL       = 3'h3;
  localparam logic [2:0]  TB_SYS_CLK        = 3'h4;
  localparam logic [2:0]  TB_EXT_OSC_DIV8   = 3'h5;

  // ----------------------------------------------------------------------------
  // Prescaler and counter counts
  // ----------------------------------------------------------------------------
  localparam logic [3:0]  DIV12_LAST        = 4'hB;
  localparam logic [3:0]  DIV4_LAST         = 4'h3;
  localparam logic [15:0] COUNT_MAX         = 16'hFFFF;
  localparam logic [15:0] COUNT_RESET       = 16'h0000;

  typedef struct packed {
    logic       idle_suspend;
    logic       watchdog_enable;
    logic       watchdog_lock;
    logic [2:0] timebase_select;
    logic       overflow_irq_enable;
  } cam_mode_s;

endpackage

// ### hdl/cam_mode_ctrl.sv
// Counter array mode register, timebase selection, 16-bit counter and overflow flag.
//
// Overview of operation
// - With idle suspend set, counter array stops while the CPU is idle.
// - Watchdog enable bit selects capture module 2 as watchdog timer.
// - Watchdog lock blocks clearing watchdog enable until the next reset.
// - Timebase select picks sysclk/12, sysclk/4, timer 0 overflow or sysclk.
// - Code 011 counts falling edges of the external count input, rate at most sysclk/4.
// - Code 101 counts external oscillator divided by 8, synchronised first.
// - Overflow interrupt enable gates the overflow flag onto the interrupt request.
// - Counter wrap from FFFF to 0000 sets a sticky overflow flag.
// - Counter advances only while the counter run bit is one.
`timescale 1ns/100ps
module cam_mode_ctrl (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        mode_wr,
  input  wire logic [7:0]  mode_wdata,
  output logic [7:0]       mode_rdata,
  input  wire logic        counter_run,
  input  wire logic        flag_clear,
  input  wire logic        cpu_idle,
  input  wire logic        timer0_ovf,
  input  wire logic        external_count_input,
  input  wire logic        ext_osc_div8,
  output logic [15:0]      count,
  output logic             counter_overflow_flag,
  output logic             counter_array_irq,
  output logic             watchdog_active,
  output logic             count_tick
);

  // ----------------------------------------------------------------------------
  // Mode register
  // ----------------------------------------------------------------------------
  cam_pkg::cam_mode_s mode_ff;
  cam_pkg::cam_mode_s nxt_mode;
  logic [7:0]         wr_masked;

  always_comb
  begin
    wr_masked = mode_wdata & cam_pkg::MODE_WRITE_MASK;
    nxt_mode  = mode_ff;
    if (mode_wr)
    begin
      if (!mode_ff.watchdog_enable)
      begin
        nxt_mode = cam_pkg::cam_mode_s'({wr_masked[7:5], wr_masked[3:0]});
      end
      else
      begin
        // Only the watchdog bits respond while the watchdog runs.
        if (!mode_ff.watchdog_lock)
        begin
          nxt_mode.watchdog_enable = wr_masked[cam_pkg::WD_ENABLE_BIT];
        end
      end
      // The lock only ever sets, in either branch; a system reset is the one way to release it.
      nxt_mode.watchdog_lock = mode_ff.watchdog_lock | wr_masked[cam_pkg::WD_LOCK_BIT];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      mode_ff <= cam_pkg::cam_mode_s'({cam_pkg::MODE_RESET[7:5], cam_pkg::MODE_RESET[3:0]});
    end
    else
    begin
      mode_ff <= nxt_mode;
    end
  end

  // ----------------------------------------------------------------------------
  // Pin synchronisers: three stages, change accepted when stages two and three agree
  // ----------------------------------------------------------------------------
  logic [2:0] eci_sync_ff;
  logic [2:0] osc_sync_ff;
  logic       eci_level_ff;
  logic       osc_level_ff;
  logic       eci_fall;
  logic       osc_rise;

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      eci_sync_ff  <= 3'h7;
      osc_sync_ff  <= 3'h0;
      eci_level_ff <= 1'b1;
      osc_level_ff <= 1'b0;
    end
    else
    begin
      eci_sync_ff <= {eci_sync_ff[1:0], external_count_input};
      osc_sync_ff <= {osc_sync_ff[1:0], ext_osc_div8};
      if (eci_sync_ff[1] == eci_sync_ff[2])
      begin
        eci_level_ff <= eci_sync_ff[2];
      end
      if (osc_sync_ff[1] == osc_sync_ff[2])
      begin
        osc_level_ff <= osc_sync_ff[2];
      end
    end
  end

  // Falling edges faster than sysclk/4 may be lost in the filter.
  assign eci_fall = eci_level_ff && (eci_sync_ff[1] == eci_sync_ff[2]) && !eci_sync_ff[2];
  assign osc_rise = !osc_level_ff && (osc_sync_ff[1] == osc_sync_ff[2]) && osc_sync_ff[2];

  // ----------------------------------------------------------------------------
  // Prescaler and tick selection
  // ----------------------------------------------------------------------------
  logic [3:0] presc_ff;
  logic       run_en;
  logic       tick;

  assign run_en = counter_run && !(mode_ff.idle_suspend && cpu_idle);

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      presc_ff <= 4'h0;
    end
    else if (run_en)
    begin
      if ((mode_ff.timebase_select == cam_pkg::TB_SYS_DIV12 && presc_ff >= cam_pkg::DIV12_LAST) ||
          (mode_ff.timebase_select == cam_pkg::TB_SYS_DIV4 && presc_ff >= cam_pkg::DIV4_LAST))
      begin
        presc_ff <= 4'h0;
      end
      else
      begin
        presc_ff <= presc_ff + 4'h1;
      end
    end
  end

  always_comb
  begin
    unique case (mode_ff.timebase_select)
      cam_pkg::TB_SYS_DIV12:    tick = presc_ff >= cam_pkg::DIV12_LAST;
      cam_pkg::TB_SYS_DIV4:     tick = presc_ff >= cam_pkg::DIV4_LAST;
      cam_pkg::TB_TIMER0_OVF:   tick = timer0_ovf;
      cam_pkg::TB_EXT_FALL:     tick = eci_fall;
      cam_pkg::TB_SYS_CLK:      tick = 1'b1;
      cam_pkg::TB_EXT_OSC_DIV8: tick = osc_rise;
      default:                  tick = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------------
  // Overflow flag
  // ----------------------------------------------------------------------------
  logic wrap_event;
  logic nxt_flag;

  assign wrap_event = run_en && tick && (count == cam_pkg::COUNT_MAX);

  // Set wins over a clear in the same cycle so no wrap is lost.
  always_comb
  begin
    nxt_flag = counter_overflow_flag;
    if (wrap_event)
    begin
      nxt_flag = 1'b1;
    end
    else if (flag_clear)
    begin
      nxt_flag = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      counter_overflow_flag <= 1'b0;
    end
    else
    begin
      counter_overflow_flag <= nxt_flag;
    end
  end

  // ----------------------------------------------------------------------------
  // Counter and outputs
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      count      <= cam_pkg::COUNT_RESET;
      count_tick <= 1'b0;
    end
    else
    begin
      count_tick <= run_en && tick;
      if (run_en && tick)
      begin
        count <= count + 16'h0001;
      end
    end
  end

  // The request follows the next flag value, so it rises and falls on the same edge as the flag.
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      counter_array_irq <= 1'b0;
      watchdog_active   <= 1'b1;
      mode_rdata        <= cam_pkg::MODE_RESET;
    end
    else
    begin
      counter_array_irq <= nxt_mode.overflow_irq_enable && nxt_flag;
      watchdog_active   <= nxt_mode.watchdog_enable;
      mode_rdata        <= {nxt_mode.idle_suspend, nxt_mode.watchdog_enable, nxt_mode.watchdog_lock,
                            1'b0, nxt_mode.timebase_select, nxt_mode.overflow_irq_enable};
    end
  end

endmodule

// ### verification/cam_mode_ctrl_properties.sv
// Concurrent checks on the mode control ports.
`timescale 1ns/100ps
module cam_mode_ctrl_properties (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic [7:0]  mode_rdata,
  input wire logic        counter_run,
  input wire logic        cpu_idle,
  input wire logic [15:0] count,
  input wire logic        counter_overflow_flag,
  input wire logic        counter_array_irq,
  input wire logic        watchdog_active,
  input wire logic        count_tick
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);
  sequence s_fast;
    (mode_rdata[3:1] == 3'h4 && counter_run && !(mode_rdata[7] && cpu_idle)) [*2];
  endsequence
  property p_fast; s_fast |-> count_tick; endproperty
  a_fast: assert property (p_fast) else $error("no tick");
  property p_step; count_tick |-> count == $past(count) + 16'h0001; endproperty
  a_step: assert property (p_step) else $error("bad step");
  property p_stop; !counter_run |=> !count_tick; endproperty
  a_stop: assert property (p_stop) else $error("tick when stopped");
  property p_idle; mode_rdata[7] && cpu_idle |=> !count_tick; endproperty
  a_idle: assert property (p_idle) else $error("tick when idle");
  property p_wrap; count_tick && count == 16'h0000 |-> counter_overflow_flag; endproperty
  a_wrap: assert property (p_wrap) else $error("no flag");
  property p_irq; $stable(mode_rdata[0]) |-> counter_array_irq == (counter_overflow_flag && mode_rdata[0]); endproperty
  a_irq: assert property (p_irq) else $error("bad irq");
  property p_lock; mode_rdata[5] && watchdog_active |=> watchdog_active && mode_rdata[5]; endproperty
  a_lock: assert property (p_lock) else $error("lock lost");
  property p_frz; watchdog_active |=> $stable({mode_rdata[7], mode_rdata[3:0]}); endproperty
  a_frz: assert property (p_frz) else $error("mode changed");
endmodule
bind cam_mode_ctrl cam_mode_ctrl_properties i_props (
  .clk                   (clk),
  .rstn                  (rstn),
  .mode_rdata            (mode_rdata),
  .counter_run           (counter_run),
  .cpu_idle              (cpu_idle),
  .count                 (count),
  .counter_overflow_flag (counter_overflow_flag),
  .counter_array_irq     (counter_array_irq),
  .watchdog_active       (watchdog_active),
  .count_tick            (count_tick)
);

// ### verification/cam_mode_ctrl_tb.sv
// Self-checking bench for the counter array mode control.
`timescale 1ns/100ps
module cam_mode_ctrl_tb;
  logic        clk, rstn, mode_wr, counter_run, flag_clear, cpu_idle, timer0_ovf;
  logic        external_count_input, ext_osc_div8, counter_overflow_flag;
  logic        counter_array_irq, watchdog_active, count_tick;
  logic [7:0]  mode_wdata, mode_rdata;
  logic [15:0] count, base;
  int          n_errors = 0;
  int          checked = 0;
  int          n_ticks = 0;
  int          tick_base;
  cam_mode_ctrl i_dut (
    .clk                   (clk),
    .rstn                  (rstn),
    .mode_wr               (mode_wr),
    .mode_wdata            (mode_wdata),
    .mode_rdata            (mode_rdata),
    .counter_run           (counter_run),
    .flag_clear            (flag_clear),
    .cpu_idle              (cpu_idle),
    .timer0_ovf            (timer0_ovf),
    .external_count_input  (external_count_input),
    .ext_osc_div8          (ext_osc_div8),
    .count                 (count),
    .counter_overflow_flag (counter_overflow_flag),
    .counter_array_irq     (counter_array_irq),
    .watchdog_active       (watchdog_active),
    .count_tick            (count_tick)
  );
  // Tick pulses are counted where they are settled, away from the edge that launches them.
  always @(negedge clk)
  begin
    if (count_tick === 1'b1)
      n_ticks++;
  end
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
    // Callers sample at the falling edge; hand back at a rising edge so they drive on it.
    @(posedge clk);
  endtask
  task automatic end_of_test;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] d);
    mode_wr <= 1'b1;
    mode_wdata <= d;
    @(posedge clk);
    mode_wr <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic t_reg;
    @(negedge clk);
    chk({mode_rdata, 7'h00, watchdog_active}, 16'h4001);
    wr(8'hC9);
    @(negedge clk);
    chk(mode_rdata, 16'h0040);
    wr(8'h00);
    @(negedge clk);
    chk(watchdog_active, 16'h0000);
  endtask
  // All sources toggle at once for the first 40 of 48 run edges, so a wrong select shows as a wrong count except among the three sources giving 5.
  task automatic t_src(input logic [7:0] m, input logic [15:0] exp);
    wr(m);
    base = count;
    tick_base = n_ticks;
    counter_run <= 1'b1;
    for (int i = 0; i < 40; i++)
    begin
      @(posedge clk);
      timer0_ovf <= i % 8 == 0;
      external_count_input <= i % 8 < 4;
      ext_osc_div8 <= i % 8 > 3;
      cpu_idle <= i[0];
    end
    @(posedge clk);
    {timer0_ovf, external_count_input, ext_osc_div8} <= 3'h0;
    cpu_idle <= 1'b0;
    repeat (7) @(posedge clk);
    counter_run <= 1'b0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk(count - base, exp);
    @(negedge clk);
    chk(16'(n_ticks - tick_base), exp);
  endtask
  task automatic t_ovf;
    wr(8'h09);
    counter_run <= 1'b1;
    for (int i = 0; i < 66000 && counter_overflow_flag !== 1'b1; i++)
      @(posedge clk);
    counter_run <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk({counter_overflow_flag, counter_array_irq}, 16'h0003);
    wr(8'h08);
    @(negedge clk);
    chk({counter_overflow_flag, counter_array_irq}, 16'h0002);
    wr(8'h09);
    @(negedge clk);
    chk({counter_overflow_flag, counter_array_irq}, 16'h0003);
    flag_clear <= 1'b1;
    @(posedge clk);
    flag_clear <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk({counter_overflow_flag, counter_array_irq}, 16'h0000);
  endtask
  task automatic t_lock;
    wr(8'h40);
    wr(8'h60);
    wr(8'h00);
    @(negedge clk);
    chk({mode_rdata, 7'h00, watchdog_active}, 16'h6001);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    wr(8'h00);
    @(negedge clk);
    chk(mode_rdata, 16'h0000);
  endtask
  initial
  begin
    {rstn, mode_wr, counter_run, flag_clear, cpu_idle, timer0_ovf} <= 6'h00;
    {external_count_input, ext_osc_div8, mode_wdata} <= 10'h000;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_reg;
    t_src(8'h00, 16'h0004);
    t_src(8'h02, 16'h000C);
    t_src(8'h04, 16'h0005);
    t_src(8'h06, 16'h0005);
    t_src(8'h08, 16'h0030);
    t_src(8'h0A, 16'h0005);
    t_src(8'h0C, 16'h0000);
    t_src(8'h88, 16'h001C);
    t_ovf;
    t_lock;
    end_of_test;
  end
  initial
  begin
    repeat (90000) @(posedge clk);
    n_errors++;
    end_of_test;
  end
endmodule
